// [core/ccm_pkg.sv]
// types shared by the capture/compare module and its pin synchroniser
// assumes ccm_regs.svh carries every number
package ccm_pkg;

    typedef logic [31:0] word_t;
    typedef logic [15:0] half_t;
    typedef logic [7:0] byte_t;

    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_CAPT = 3'b001,
        MODE_CMP = 3'b011,
        MODE_FREQ = 3'b010,
        MODE_PULSE_MODE_ENABLE = 3'b110,
        MODE_PWM16 = 3'b111
    } op_mode_t;

    typedef enum logic [2:0] {
        REG_MODE = 3'b000,
        REG_PWM = 3'b001,
        REG_CPL = 3'b011,
        REG_CPH = 3'b010,
        REG_STAT = 3'b110,
        REG_NONE = 3'b111
    } reg_idx_t;

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_t;

    typedef struct packed {
        byte_t mode;
        byte_t pwmcfg;
        half_t cmp;
        half_t reload;
        logic evt_flag;
        logic ovf_flag;
        logic pin;
        logic pin_oe;
        logic pin_prev;
        logic wr_pend;
        reg_idx_t wr_idx;
        word_t rdata;
        logic hready;
        logic evt_irq;
        logic ovf_irq;
    } state_t;

endpackage : ccm_pkg

// [core/ccm_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a byte-addressed AHB-Lite word map, one register per word
//
// Functional notes
// [R01] capture counter on selected pin edges
// [R02] capture sets event flag, may interrupt
// [R03] event flag only cleared by software
// [R04] pin held stable two clocks minimum
// [R05] software timer flags on 16-bit match
// [R06] low byte write clears, high sets enable
// [R07] software writes low byte before high
// [R08] high-speed mode toggles pin on match
// [R09] disabled comparator holds pin, pwm low
// [R10] frequency mode toggles, adds half period
// [R11] frequency is timebase over twice high
// [R12] frequency mode flags full 16-bit match
// [R13] one shared cycle length for pwm
// [R14] 8-bit pwm: high on match, low overflow
// [R15] 8-bit pwm reloads low from high
// [R16] pwm match flag and shared overflow flag
// [R17] config bit 7 steers to reload register
// [R18] config bit 5 enables overflow interrupt
// [R19] mode bit 0 enables event interrupt
// [R20] 16-bit pwm with optional auto-reload
// [R21] n-bit pwm match, overflow, reload
// [R22] 16-bit pwm high on match, low wrap
// [R23] one evaluation per tick, synced pin
`ifndef CCM_REGS_SVH
`define CCM_REGS_SVH

`define OFF_MODE 8'h00
`define OFF_PWM 8'h04
`define OFF_CPL 8'h08
`define OFF_CPH 8'h0c
`define OFF_STAT 8'h10

`define MODE_IRQ 0
`define MODE_PWM 1
`define MODE_TOG 2
`define MODE_MAT 3
`define MODE_FALL 4
`define MODE_RISE 5
`define MODE_ECOM 6
`define MODE_P16 7

`define PWM_RELOAD_ACCESS_SEL 7
`define PWM_CYCLE_OVERFLOW_FLAG 6
`define PWM_OVERFLOW_IRQ_ENABLE 5
`define PWM_AR16 3
`define PWM_WMASK 8'haf

`define STAT_EVT 0
`define STAT_OVF 1

`define MODE_RST 8'h00
`define PWM_RST 8'h00
`define CMP_RST 16'h0000

`define PIN_MIN_HOLD_CYC 2

`endif

// [core/counter_array_capture_compare_module.sv]
// one capture/compare module of the counter array with an AHB-Lite slave
// assumes the shared 16-bit counter and its timebase tick come from outside
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`include "ccm_regs.svh"
`timescale 1ns/1ps
module counter_array_capture_compare_module (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire ccm_pkg::word_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire ccm_pkg::word_t hwdata,
    input wire logic hready,
    output ccm_pkg::word_t hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ccm_pkg::half_t counter_value,
    input wire logic count_step,
    input wire logic module_io_pin_in,
    output logic module_io_pin_out,
    output logic module_io_pin_oe,
    output logic event_irq,
    output logic overflow_irq
);
    import ccm_pkg::*;

    localparam state_t ST_RST = '{
        mode: `MODE_RST,
        pwmcfg: `PWM_RST,
        cmp: `CMP_RST,
        reload: `CMP_RST,
        wr_idx: REG_NONE,
        hready: 1'b1,
        pin_oe: 1'b1,
        default: '0
    };

    // address phase decode
    function automatic reg_idx_t reg_of(input word_t a);
        reg_idx_t r;
        r = REG_NONE;
        if (a[31:8] == 24'h000000) begin
            unique case (a[7:0])
                `OFF_MODE: r = REG_MODE;
                `OFF_PWM: r = REG_PWM;
                `OFF_CPL: r = REG_CPL;
                `OFF_CPH: r = REG_CPH;
                `OFF_STAT: r = REG_STAT;
                default: r = REG_NONE;
            endcase
        end
        return r;
    endfunction : reg_of

    // operating mode from the mode bits
    function automatic op_mode_t mode_of(input byte_t m);
        op_mode_t r;
        if (m[`MODE_RISE] || m[`MODE_FALL]) begin
            r = MODE_CAPT;
        end else if (m[`MODE_PWM] && m[`MODE_P16]) begin
            r = MODE_PWM16;
        end else if (m[`MODE_PWM] && m[`MODE_TOG]) begin
            r = MODE_FREQ;
        end else if (m[`MODE_PWM]) begin
            r = MODE_PULSE_MODE_ENABLE;
        end else if (m[`MODE_MAT] || m[`MODE_TOG]) begin
            r = MODE_CMP;
        end else begin
            r = MODE_IDLE;
        end
        return r;
    endfunction : mode_of

    // low n counter bits, n = 8 + cycle length select
    function automatic half_t cycle_mask(input logic [2:0] sel);
        return 16'hffff >> (4'd8 - {1'b0, sel});
    endfunction : cycle_mask

    state_t s_q;
    state_t s_d;
    logic pin_sync_lvl;
    op_mode_t op_mode;
    half_t mask;
    half_t eff;
    logic [2:0] cycle_length_sel;
    logic reload_access_sel;
    logic comparator_enable;
    logic match_flag_enable;
    logic rolled;
    logic wrap16;
    logic rise_edge;
    logic fall_edge;
    logic evt_set;
    logic ovf_set;
    reg_idx_t a_idx;
    logic a_take;

    pin_sync u_pin_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .din(module_io_pin_in),
        .dout(pin_sync_lvl)
    );

    always_comb begin
        s_d = s_q;
        cycle_length_sel = s_q.pwmcfg[2:0]; // [R13]
        reload_access_sel = s_q.pwmcfg[`PWM_RELOAD_ACCESS_SEL];
        comparator_enable = s_q.mode[`MODE_ECOM];
        match_flag_enable = s_q.mode[`MODE_MAT];
        op_mode = mode_of(s_q.mode);
        mask = cycle_mask(cycle_length_sel);
        rolled = count_step && ((counter_value & mask) == 16'h0000);
        wrap16 = count_step && (counter_value == 16'h0000);
        rise_edge = pin_sync_lvl && !s_q.pin_prev; // [R23]
        fall_edge = !pin_sync_lvl && s_q.pin_prev;
        evt_set = 1'b0;
        ovf_set = rolled; // [R16] [R21]
        eff = s_q.cmp;
        a_idx = reg_of(haddr);
        a_take = hsel && hready && htrans[1];

        // bus: data phase of a write
        s_d.wr_pend = 1'b0;
        if (s_q.wr_pend) begin
            unique case (s_q.wr_idx)
                REG_MODE: begin
                    s_d.mode = hwdata[7:0];
                end
                REG_PWM: begin
                    s_d.pwmcfg = hwdata[7:0] & `PWM_WMASK;
                end
                REG_CPL: begin
                    if (reload_access_sel) begin // [R17]
                        s_d.reload[7:0] = hwdata[7:0];
                    end else begin
                        s_d.cmp[7:0] = hwdata[7:0];
                        s_d.mode[`MODE_ECOM] = 1'b0; // [R06]
                    end
                end
                REG_CPH: begin
                    if (reload_access_sel) begin // [R17]
                        s_d.reload[15:8] = hwdata[7:0];
                    end else begin
                        s_d.cmp[15:8] = hwdata[7:0];
                        s_d.mode[`MODE_ECOM] = 1'b1; // [R06]
                    end
                end
                REG_STAT: begin
                    if (hwdata[`STAT_EVT]) begin
                        s_d.evt_flag = 1'b0; // [R03]
                    end
                    if (hwdata[`STAT_OVF]) begin
                        s_d.ovf_flag = 1'b0;
                    end
                end
                REG_NONE: begin
                end
            endcase
        end

        // hardware behaviour per mode
        unique case (op_mode)
            MODE_CAPT: begin
                if ((rise_edge && s_q.mode[`MODE_RISE])
                        || (fall_edge && s_q.mode[`MODE_FALL])) begin
                    s_d.cmp = counter_value; // [R01]
                    evt_set = 1'b1; // [R02]
                end
            end
            MODE_CMP: begin
                if (count_step && (counter_value == s_q.cmp)) begin
                    if (match_flag_enable) begin
                        evt_set = 1'b1; // [R05] [R08]
                    end
                    if (comparator_enable && s_q.mode[`MODE_TOG]) begin
                        s_d.pin = !s_q.pin; // [R08] [R09]
                    end
                end
            end
            MODE_FREQ: begin
                if (count_step && comparator_enable) begin
                    if (counter_value[7:0] == s_q.cmp[7:0]) begin
                        s_d.pin = !s_q.pin; // [R10] [R09]
                        s_d.cmp[7:0] = s_q.cmp[7:0] + s_q.cmp[15:8]; // [R10] [R11]
                    end
                    if (match_flag_enable && (counter_value == s_q.cmp)) begin
                        evt_set = 1'b1; // [R12]
                    end
                end
            end
            MODE_PULSE_MODE_ENABLE: begin
                if (cycle_length_sel == 3'b000) begin
                    if (rolled) begin
                        s_d.pin = 1'b0; // [R14]
                        s_d.cmp[7:0] = s_q.cmp[15:8]; // [R15]
                        eff = {s_q.cmp[15:8], s_q.cmp[15:8]};
                    end
                    if (count_step && (counter_value[7:0] == eff[7:0])) begin
                        s_d.pin = 1'b1; // [R14]
                        evt_set = match_flag_enable; // [R16]
                    end
                end else begin
                    if (rolled) begin
                        s_d.pin = 1'b0; // [R21]
                        s_d.cmp = s_q.reload & mask; // [R21]
                        eff = s_q.reload & mask;
                    end
                    if (count_step && ((counter_value & mask) == (eff & mask))) begin
                        s_d.pin = 1'b1; // [R21]
                        evt_set = match_flag_enable;
                    end
                end
                if (!comparator_enable) begin
                    s_d.pin = 1'b0; // [R09]
                    evt_set = 1'b0;
                end
            end
            MODE_PWM16: begin
                if (wrap16) begin
                    s_d.pin = 1'b0; // [R22]
                    if (s_q.pwmcfg[`PWM_AR16]) begin
                        s_d.cmp = s_q.reload; // [R20]
                        eff = s_q.reload;
                    end
                end
                if (count_step && (counter_value == eff)) begin
                    s_d.pin = 1'b1; // [R22] [R20]
                    evt_set = match_flag_enable;
                end
                if (!comparator_enable) begin
                    s_d.pin = 1'b0; // [R09]
                    evt_set = 1'b0;
                end
            end
            MODE_IDLE: begin
            end
        endcase

        // set wins over a clear in the same cycle
        if (evt_set) begin
            s_d.evt_flag = 1'b1; // [R02] [R03]
        end
        if (ovf_set) begin
            s_d.ovf_flag = 1'b1; // [R16]
        end

        s_d.pin_prev = pin_sync_lvl;
        s_d.pin_oe = !(s_d.mode[`MODE_RISE] || s_d.mode[`MODE_FALL]);
        s_d.evt_irq = s_d.evt_flag && s_d.mode[`MODE_IRQ]; // [R19] [R02]
        s_d.ovf_irq = s_d.ovf_flag && s_d.pwmcfg[`PWM_OVERFLOW_IRQ_ENABLE]; // [R18]

        // bus: address phase
        s_d.hready = 1'b1;
        s_d.rdata = 32'h00000000;
        if (a_take) begin
            if (hwrite) begin
                s_d.wr_pend = 1'b1;
                s_d.wr_idx = a_idx;
            end else begin
                unique case (a_idx)
                    REG_MODE: begin
                        s_d.rdata[7:0] = s_q.mode;
                    end
                    REG_PWM: begin
                        s_d.rdata[7:0] = s_q.pwmcfg;
                        s_d.rdata[`PWM_CYCLE_OVERFLOW_FLAG] = s_q.ovf_flag;
                    end
                    REG_CPL: begin
                        s_d.rdata[7:0] = reload_access_sel ? s_q.reload[7:0] : s_q.cmp[7:0];
                    end
                    REG_CPH: begin
                        s_d.rdata[7:0] = reload_access_sel ? s_q.reload[15:8]
                                                           : s_q.cmp[15:8];
                    end
                    REG_STAT: begin
                        s_d.rdata[`STAT_EVT] = s_q.evt_flag;
                        s_d.rdata[`STAT_OVF] = s_q.ovf_flag;
                    end
                    REG_NONE: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= ST_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = s_q.hready;
    assign hresp = 1'b0;
    assign module_io_pin_out = s_q.pin;
    assign module_io_pin_oe = s_q.pin_oe;
    assign event_irq = s_q.evt_irq;
    assign overflow_irq = s_q.ovf_irq;

    logic unused_ok;
    assign unused_ok = ^{hsize, hwdata[31:8]};

endmodule : counter_array_capture_compare_module

// [core/pin_sync.sv]
// two-stage synchroniser for the module pin input
// assumes the pin is held stable for a minimum number of clocks
`timescale 1ns/1ps
module pin_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    import ccm_pkg::*;

    sync_t s_q;
    sync_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.meta = din;
        s_d.stable = s_q.meta; // [R23] [R04]
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.stable;

endmodule : pin_sync

// [tb/ccm_monitor.sv]
// concurrent checks on the capture/compare module ports
// assumes a byte-addressed bus map and bind to the design top
`include "ccm_regs.svh"
`timescale 1ns/1ps
module ccm_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire ccm_pkg::word_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire ccm_pkg::word_t hwdata,
    input wire logic hready,
    input wire ccm_pkg::half_t counter_value,
    input wire logic count_step,
    input wire logic module_io_pin_out,
    input wire logic module_io_pin_oe,
    input wire logic event_irq,
    input wire logic overflow_irq
);
    import ccm_pkg::*;
    logic wp_q;
    logic cmp_ok_q;
    logic [7:0] wa_q;
    logic [7:0] mode_q;
    logic [7:0] cfg_q;
    half_t cmp_q;
    logic [1:0] quiet_q;
    // shadow of the registers written over the bus
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {wp_q, cmp_ok_q, wa_q, mode_q, cfg_q, cmp_q, quiet_q} <= '0;
        end else if (ce) begin
            wp_q <= hsel && hready && htrans[1] && hwrite;
            wa_q <= haddr[7:0];
            quiet_q <= wp_q ? 2'd0 : (quiet_q == 2'd3 ? 2'd3 : quiet_q + 2'd1);
            if (wp_q && wa_q == `OFF_MODE) mode_q <= hwdata[7:0];
            if (wp_q && wa_q == `OFF_PWM) cfg_q <= hwdata[7:0];
            if (wp_q && wa_q == `OFF_CPL && !cfg_q[7]) begin
                cmp_q[7:0] <= hwdata[7:0];
                mode_q[6] <= 1'b0;
            end
            if (wp_q && wa_q == `OFF_CPH && !cfg_q[7]) begin
                cmp_q[15:8] <= hwdata[7:0];
                mode_q[6] <= 1'b1;
                cmp_ok_q <= 1'b1;
            end
            if (|mode_q[5:4] || (mode_q[1] && !mode_q[7]) || cfg_q[3]) cmp_ok_q <= 1'b0;
        end
    end
    wire calm = quiet_q == 2'd3;
    wire cap = |mode_q[5:4];
    wire hs = calm && !cap && !mode_q[1] && mode_q[2] && mode_q[3];
    wire pwm = calm && !cap && mode_q[1] && !mode_q[2];
    wire p16 = pwm && mode_q[7] && mode_q[6] && !cfg_q[3] && cmp_ok_q && cmp_q != 16'h0000;
    wire hit = count_step && counter_value == cmp_q && cmp_ok_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_oe_capture: assert property (calm && cap |-> !module_io_pin_oe)
        else $error("pin driven in capture mode");
    a_pwm_zero: assert property (pwm && !mode_q[6] && count_step |=> !module_io_pin_out)
        else $error("pwm output high with comparator off");
    a_hs_hold: assert property (hs && !mode_q[6] |-> $stable(module_io_pin_out))
        else $error("pin moved with comparator off");
    a_hs_toggle: assert property (hs && mode_q[6] && hit
        |=> module_io_pin_out != $past(module_io_pin_out))
        else $error("no toggle on match");
    a_p16_high: assert property (p16 && hit |=> module_io_pin_out)
        else $error("wide pwm not high on match");
    a_p16_low: assert property (p16 && count_step && counter_value == 16'h0000
        |=> !module_io_pin_out)
        else $error("wide pwm not low on wrap");
    a_irq_gate: assert property (calm && !mode_q[0] |-> !event_irq)
        else $error("event irq while disabled");
    a_ovf_gate: assert property (calm && !cfg_q[5] |-> !overflow_irq)
        else $error("overflow irq while disabled");
    a_timer_irq: assert property (calm && !cap && !mode_q[1] && mode_q[3] && mode_q[0] && hit
        |-> ##[1:2] event_irq)
        else $error("no event irq on timer match");
endmodule : ccm_monitor

bind counter_array_capture_compare_module ccm_monitor u_mon (
    .mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .counter_value(counter_value),
    .count_step(count_step), .module_io_pin_out(module_io_pin_out),
    .module_io_pin_oe(module_io_pin_oe), .event_irq(event_irq), .overflow_irq(overflow_irq));

// [tb/pin_source.sv]
// external source on the module pin, resolves the wire level
// assumes want is driven by the bench; changes spaced at least three clocks apart
`timescale 1ns/1ps
module pin_source (
    input wire logic mclk,
    input wire logic want,
    input wire logic oe,
    input wire logic drv,
    output logic pin
);
    logic lvl_q = 1'b0;
    logic [1:0] age_q = 2'd0;
    always @(posedge mclk) begin
        if (want != lvl_q && age_q >= 2'd2) begin
            lvl_q <= want;
            age_q <= 2'd0;
        end else if (age_q != 2'd3) begin
            age_q <= age_q + 2'd1;
        end
    end
    assign pin = oe ? drv : lvl_q;
endmodule : pin_source

// [tb/testbench.sv]
// self-checking bench for the capture/compare module
// assumes one bus slave, ce held high, pin source model on the pin
`include "ccm_regs.svh"
`timescale 1ns/1ps
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin err_total++; \
    $display("MISMATCH t=%0t got %h want %h", $time, g, w); end end
module testbench;
    import ccm_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic count_step = 1'b0;
    logic want = 1'b0;
    logic [1:0] htrans = 2'b00;
    word_t haddr = '0;
    word_t hwdata = '0;
    half_t counter_value = '0;
    word_t hrdata;
    logic hreadyout, hresp, pin_out, pin_oe, event_irq, overflow_irq, pin_in;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    always #12.5 mclk = ~mclk;
    counter_array_capture_compare_module DUT (.mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .counter_value(counter_value), .count_step(count_step), .module_io_pin_in(pin_in),
        .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe), .event_irq(event_irq),
        .overflow_irq(overflow_irq));
    pin_source u_src (.mclk(mclk), .want(want), .oe(pin_oe), .drv(pin_out), .pin(pin_in));
    task report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            report_and_stop();
        end
    end
    task bus(input byte_t a, input logic w, input byte_t d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask : bus
    task bwr(input byte_t a, input byte_t d);
        bus(a, 1'b1, d);
    endtask : bwr
    task bchk(input byte_t a, input byte_t w);
        bus(a, 1'b0, 8'h00);
        `CHK(hrdata, {24'h0, w})
        `CHK(hresp, 1'b0)
    endtask : bchk
    task step(input half_t v);
        counter_value <= v;
        repeat (3) @(posedge mclk);
        count_step <= 1'b1;
        @(posedge mclk);
        count_step <= 1'b0;
        @(posedge mclk);
    endtask : step
    task highs(input int first, input int n, output int cnt);
        cnt = 0;
        for (int i = first; i < first + n; i++) begin
            step(half_t'(i));
            if (pin_out === 1'b1) cnt++;
        end
    endtask : highs
    task t_reset;
        bchk(`OFF_MODE, `MODE_RST);
        bchk(`OFF_PWM, `PWM_RST);
        bchk(`OFF_CPL, 8'h00);
        bchk(`OFF_CPH, 8'h00);
        bchk(`OFF_STAT, 8'h00);
        bchk(8'h20, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task t_timer;
        bwr(`OFF_MODE, 8'h49);
        bwr(`OFF_CPL, 8'h34);
        bchk(`OFF_MODE, 8'h09);
        bwr(`OFF_CPH, 8'h12);
        bchk(`OFF_MODE, 8'h49);
        step(16'h1233);
        `CHK(event_irq, 1'b0)
        step(16'h1234);
        `CHK(event_irq, 1'b1)
        step(16'h1235);
        bchk(`OFF_STAT, 8'h01);
        bwr(`OFF_STAT, 8'h01);
        bchk(`OFF_STAT, 8'h00);
        bwr(`OFF_MODE, 8'h48);
        step(16'h1234);
        `CHK(event_irq, 1'b0)
        bchk(`OFF_STAT, 8'h01);
        $display("timer test done");
    endtask : t_timer
    task cap_edge(input logic lv, input half_t cv, input logic hit, inout half_t last);
        bwr(`OFF_STAT, 8'h01);
        counter_value <= cv;
        want <= lv;
        repeat (8) @(posedge mclk);
        if (hit) last = cv;
        `CHK(pin_oe, 1'b0)
        `CHK(event_irq, hit)
        bchk(`OFF_CPL, last[7:0]);
        bchk(`OFF_CPH, last[15:8]);
        bchk(`OFF_STAT, {7'h0, hit});
    endtask : cap_edge
    task t_capture;
        half_t last;
        byte_t m;
        last = 16'h1234;
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 8'h21 : (i == 1) ? 8'h11 : 8'h31;
            bwr(`OFF_MODE, m);
            cap_edge(1'b1, half_t'(16'h5a00 + i), m[5], last);
            cap_edge(1'b0, half_t'(16'ha500 + i), m[4], last);
        end
        $display("capture test done");
    endtask : t_capture
    task t_hs;
        logic p;
        bwr(`OFF_MODE, 8'h4c);
        bwr(`OFF_CPL, 8'h10);
        bwr(`OFF_CPH, 8'h00);
        bwr(`OFF_STAT, 8'h01);
        p = pin_out;
        step(16'h0010);
        `CHK(pin_out, ~p)
        step(16'h0011);
        step(16'h0010);
        `CHK(pin_out, p)
        bchk(`OFF_STAT, 8'h01);
        bwr(`OFF_CPL, 8'h10);
        step(16'h0010);
        `CHK(pin_out, p)
        $display("high speed test done");
    endtask : t_hs
    task t_freq;
        int n;
        logic p;
        bwr(`OFF_MODE, 8'h46);
        for (int k = 0; k < 2; k++) begin
            bwr(`OFF_CPL, 8'h00);
            bwr(`OFF_CPH, k == 0 ? 8'h04 : 8'h00);
            bwr(`OFF_STAT, 8'h01);
            n = 0;
            for (int i = 0; i < (k == 0 ? 32 : 512); i++) begin
                p = pin_out;
                step(half_t'(i));
                if (pin_out !== p) n++;
            end
            `CHK(n, k == 0 ? 8 : 2)
            bchk(`OFF_STAT, 8'h02);
        end
        $display("frequency test done");
    endtask : t_freq
    task t_pwm8;
        int n;
        bwr(`OFF_PWM, 8'h20);
        bwr(`OFF_MODE, 8'h4a);
        bwr(`OFF_CPL, 8'hc0);
        bwr(`OFF_CPH, 8'hc0);
        bwr(`OFF_STAT, 8'h03);
        highs(0, 16, n);
        bwr(`OFF_CPH, 8'h40);
        highs(16, 240, n);
        `CHK(n, 64)
        highs(0, 256, n);
        `CHK(n, 192)
        bchk(`OFF_STAT, 8'h03);
        bchk(`OFF_PWM, 8'h60);
        `CHK(overflow_irq, 1'b1)
        bwr(`OFF_STAT, 8'h02);
        bwr(`OFF_CPL, 8'h40);
        highs(0, 80, n);
        `CHK(n, 0)
        `CHK(overflow_irq, 1'b1)
        $display("pwm8 test done");
    endtask : t_pwm8
    task t_pwm9;
        int n;
        bwr(`OFF_PWM, 8'h01);
        bwr(`OFF_CPL, 8'h80);
        bwr(`OFF_CPH, 8'h01);
        bwr(`OFF_PWM, 8'h81);
        bwr(`OFF_CPL, 8'h00);
        bwr(`OFF_CPH, 8'h01);
        bchk(`OFF_CPL, 8'h00);
        bwr(`OFF_PWM, 8'h01);
        bchk(`OFF_CPL, 8'h80);
        highs(0, 512, n);
        `CHK(n, 256)
        bchk(`OFF_CPL, 8'h00);
        bchk(`OFF_PWM, 8'h41);
        $display("pwm9 test done");
    endtask : t_pwm9
    task t_pwm16;
        bwr(`OFF_PWM, 8'h00);
        bwr(`OFF_MODE, 8'hc2);
        bwr(`OFF_CPL, 8'hf0);
        bwr(`OFF_CPH, 8'hff);
        step(16'hfff0);
        `CHK(pin_out, 1'b1)
        step(16'h0000);
        `CHK(pin_out, 1'b0)
        bwr(`OFF_PWM, 8'h88);
        bwr(`OFF_CPL, 8'h00);
        bwr(`OFF_CPH, 8'h80);
        bwr(`OFF_PWM, 8'h08);
        step(16'hfff0);
        `CHK(pin_out, 1'b1)
        step(16'h0000);
        step(16'h8000);
        `CHK(pin_out, 1'b1)
        bchk(`OFF_CPH, 8'h80);
        $display("pwm16 test done");
    endtask : t_pwm16
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_timer();
        t_capture();
        t_hs();
        t_freq();
        t_pwm8();
        t_pwm9();
        t_pwm16();
        report_and_stop();
    end
endmodule : testbench
